// ---- ddrsp_pkg.sv ----
// Shared constants and carrier types for the double-data-rate burst-of-four SRAM port.
package ddrsp_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BEATS = 4;
  // Half-cycle ticks from the command edge to the first read beat.
  localparam int RD_LAT_TICKS = 5;
  localparam int BYPASS_LAT_TICKS = 2;
  localparam int RD_PIPE_LEN = RD_LAT_TICKS + BEATS;
  localparam int WR_FIRST_TICK = 2;
  localparam int WR_COMMIT_TICK = 6;
  localparam int WR_PIPE_LEN = WR_COMMIT_TICK + 1;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STOP_TIME_PS = 30000;
  localparam int STOP_CYCLES = (STOP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_CYCLES = 2048;
  localparam int ZQ_SETTLE_CYCLES = 1024;
  localparam int ZQ_W = 6;
  localparam logic [ZQ_W-1:0] ZQ_MID = 6'h20;
  localparam logic [ZQ_W-1:0] ZQ_MAX = 6'h3F;
  // Full sweep from mid-range takes 32 steps; a 64th of the settle time per step leaves half as margin.
  localparam int ZQ_STEP_CYCLES = ZQ_SETTLE_CYCLES / 64;

  typedef struct packed {
    logic k;
    logic kc;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] raddr;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] bw_n;
    logic bypass_n;
    logic zq_up;
  } ddrsp_pins_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } ddrsp_rd_type;

  typedef struct packed {
    logic valid;
    logic slot;
  } ddrsp_wr_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [BEATS*DATA_W-1:0] data;
    logic [BEATS*LANES-1:0] mask;
  } ddrsp_wbuf_type;
endpackage

// ---- ddrsp_port.sv ----
// Device-side port logic of a burst-of-four double-data-rate SRAM with separate read and write ports.
`timescale 1ns/10ps
module ddrsp_port #(
  parameter int STOP_CYC = ddrsp_pkg::STOP_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic primary_timing_true_i,
  input wire logic primary_timing_comp_i,
  input wire logic read_select_n_i,
  input wire logic write_select_n_i,
  input wire logic [ddrsp_pkg::ADDR_W-1:0] read_addr_i,
  input wire logic [ddrsp_pkg::ADDR_W-1:0] write_addr_i,
  input wire logic [ddrsp_pkg::DATA_W-1:0] write_data_i,
  input wire logic [ddrsp_pkg::LANES-1:0] byte_write_n_i,
  input wire logic loop_bypass_n_i,
  input wire logic impedance_up_i,
  output logic [ddrsp_pkg::DATA_W-1:0] read_data_o,
  output logic echo_strobe_o,
  output logic echo_strobe_comp_o,
  output logic read_valid_flag_o,
  output logic [ddrsp_pkg::ZQ_W-1:0] impedance_code_o,
  output logic dll_locked_o
);
  import ddrsp_pkg::*;

  ddrsp_pins_type pins_a;
  ddrsp_pins_type pins_b;
  logic k_prev;
  logic kc_prev;
  logic bypass_prev;
  logic k_rise;
  logic c_rise;
  logic tick;
  logic bypass;
  int unsigned lat;

  // Synchronisers come out of reset at the idle pin levels, so no false link edge or select follows reset.
  localparam ddrsp_pins_type PINS_IDLE = '{kc: 1'b1, rd_n: 1'b1, wr_n: 1'b1, bw_n: '1, bypass_n: 1'b1, default: '0};

  // Every pin, the link clocks included, is sampled by the local clock through two flops.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_a <= PINS_IDLE;
      pins_b <= PINS_IDLE;
      k_prev <= 1'b0;
      kc_prev <= 1'b1;
      bypass_prev <= 1'b1;
    end else begin
      pins_a <= {primary_timing_true_i, primary_timing_comp_i, read_select_n_i, write_select_n_i, read_addr_i,
                 write_addr_i, write_data_i, byte_write_n_i, loop_bypass_n_i, impedance_up_i};
      pins_b <= pins_a;
      k_prev <= pins_b.k;
      kc_prev <= pins_b.kc;
      bypass_prev <= pins_b.bypass_n;
    end
  end

  assign k_rise = pins_b.k & ~k_prev;
  assign c_rise = pins_b.kc & ~kc_prev;
  assign tick = k_rise | c_rise;
  assign bypass = ~pins_b.bypass_n;
  assign lat = bypass ? BYPASS_LAT_TICKS : RD_LAT_TICKS;

  logic [DATA_W-1:0] mem [0:(1 << (ADDR_W + 2)) - 1];
  ddrsp_rd_type rpipe [RD_PIPE_LEN];
  ddrsp_rd_type next_rpipe [RD_PIPE_LEN];
  ddrsp_wr_type wpipe [WR_PIPE_LEN];
  ddrsp_wr_type next_wpipe [WR_PIPE_LEN];
  ddrsp_wbuf_type wbuf [2];
  ddrsp_wbuf_type next_wbuf [2];
  logic wr_ptr;
  logic next_wr_ptr;
  logic [DATA_W-1:0] next_read_data;
  logic next_echo;
  logic next_valid_flag;
  logic rd_accept;
  logic wr_accept;
  logic first_beat;
  logic commit_now;
  logic commit_slot;

  function automatic logic [ADDR_W+1:0] word_index(input logic [ADDR_W-1:0] base, input int unsigned beat);
    word_index = {base, beat[1:0]};
  endfunction

  // Read and write ports are separate pipelines advanced by half-cycle ticks of the link clock.
  always_comb begin
    ddrsp_wbuf_type hit;
    logic [ADDR_W-1:0] raddr;
    int unsigned beat;
    hit = '0;
    raddr = '0;
    beat = 0;
    next_rpipe = rpipe;
    next_wpipe = wpipe;
    next_wbuf = wbuf;
    next_wr_ptr = wr_ptr;
    next_read_data = read_data_o;
    next_echo = echo_strobe_o;
    next_valid_flag = read_valid_flag_o;
    rd_accept = k_rise & ~pins_b.rd_n & ~rpipe[1].valid;
    wr_accept = k_rise & ~pins_b.wr_n & ~wpipe[1].valid;
    first_beat = 1'b0;
    commit_now = 1'b0;
    commit_slot = 1'b0;
    if (tick) begin
      // A high read select inserts an empty slot; bursts already in the pipe keep shifting.
      for (int j = RD_PIPE_LEN - 1; j > 0; j--) begin
        next_rpipe[j] = rpipe[j-1];
      end
      next_rpipe[0] = '{valid: rd_accept, addr: pins_b.raddr};
      for (int j = WR_PIPE_LEN - 1; j > 0; j--) begin
        next_wpipe[j] = wpipe[j-1];
      end
      next_wpipe[0] = '{valid: wr_accept, slot: wr_ptr};
      next_echo = k_rise;
      // Commit happens before a new allocation, so a reused slot is never clobbered early.
      if (next_wpipe[WR_COMMIT_TICK].valid) begin
        commit_now = 1'b1;
        commit_slot = next_wpipe[WR_COMMIT_TICK].slot;
        next_wbuf[commit_slot].valid = 1'b0;
      end
      if (wr_accept) begin
        next_wbuf[wr_ptr] = '{valid: 1'b1, addr: pins_b.waddr, data: '0, mask: '0};
        next_wr_ptr = ~wr_ptr;
      end
      for (int j = WR_FIRST_TICK; j < WR_FIRST_TICK + BEATS; j++) begin
        if (next_wpipe[j].valid) begin
          beat = j - WR_FIRST_TICK;
          next_wbuf[next_wpipe[j].slot].data[beat*DATA_W +: DATA_W] = pins_b.wdata;
          next_wbuf[next_wpipe[j].slot].mask[beat*LANES +: LANES] = ~pins_b.bw_n;
        end
      end
      for (int b = 0; b < BEATS; b++) begin
        if (next_rpipe[lat + b].valid) begin
          raddr = next_rpipe[lat + b].addr;
          beat = b;
          first_beat = (b == 0);
          next_read_data = mem[word_index(raddr, beat)];
          // Older buffer first, then the newer one, so the latest write wins each lane.
          for (int s = 0; s < 2; s++) begin
            hit = wbuf[(s == 0) ? wr_ptr : ~wr_ptr];
            if (hit.valid && hit.addr == raddr) begin
              for (int l = 0; l < LANES; l++) begin
                if (hit.mask[beat*LANES + l]) begin
                  next_read_data[l*LANE_W +: LANE_W] = hit.data[beat*DATA_W + l*LANE_W +: LANE_W];
                end
              end
            end
          end
        end
      end
      if (next_rpipe[lat - 1].valid) begin
        next_valid_flag = 1'b1;
      end else if (next_rpipe[lat + 2].valid && !next_rpipe[lat - 2].valid) begin
        next_valid_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rpipe <= '{default: '0};
      wpipe <= '{default: '0};
      wbuf <= '{default: '0};
      wr_ptr <= 1'b0;
      read_data_o <= '0;
      echo_strobe_o <= 1'b0;
      echo_strobe_comp_o <= 1'b1;
      read_valid_flag_o <= 1'b0;
    end else begin
      rpipe <= next_rpipe;
      wpipe <= next_wpipe;
      wbuf <= next_wbuf;
      wr_ptr <= next_wr_ptr;
      read_data_o <= next_read_data;
      echo_strobe_o <= next_echo;
      echo_strobe_comp_o <= ~next_echo;
      read_valid_flag_o <= next_valid_flag;
    end
  end

  // The array has no reset; its contents are undefined until written.
  always_ff @(posedge clock_i) begin
    if (commit_now) begin
      for (int b = 0; b < BEATS; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (wbuf[commit_slot].mask[b*LANES + l]) begin
            mem[word_index(wbuf[commit_slot].addr, b)][l*LANE_W +: LANE_W] <=
              wbuf[commit_slot].data[b*DATA_W + l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  // Loop reset and lock tracking.
  logic [$clog2(STOP_CYC + 1)-1:0] stop_cnt;
  logic [$clog2(STOP_CYC + 1)-1:0] next_stop_cnt;
  logic [11:0] lock_cnt;
  logic [11:0] next_lock_cnt;
  logic dll_reset;

  always_comb begin
    next_stop_cnt = stop_cnt;
    next_lock_cnt = lock_cnt;
    if (tick) begin
      next_stop_cnt = '0;
    end else if (stop_cnt < STOP_CYC[$bits(stop_cnt)-1:0]) begin
      next_stop_cnt = stop_cnt + 1'b1;
    end
    dll_reset = (pins_b.bypass_n & ~bypass_prev) | (stop_cnt >= STOP_CYC[$bits(stop_cnt)-1:0]);
    if (dll_reset) begin
      next_lock_cnt = '0;
    end else if (k_rise && lock_cnt < LOCK_CYCLES[11:0]) begin
      next_lock_cnt = lock_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_cnt <= '0;
      lock_cnt <= '0;
      dll_locked_o <= 1'b0;
    end else begin
      stop_cnt <= next_stop_cnt;
      lock_cnt <= next_lock_cnt;
      dll_locked_o <= (next_lock_cnt == LOCK_CYCLES[11:0]);
    end
  end

  // Impedance tracking: one step per period toward the pad comparator, forever, to follow drift.
  logic [$clog2(ZQ_STEP_CYCLES)-1:0] zq_timer;
  logic [$clog2(ZQ_STEP_CYCLES)-1:0] next_zq_timer;
  logic [ZQ_W-1:0] next_zq_code;

  always_comb begin
    next_zq_timer = zq_timer + 1'b1;
    next_zq_code = impedance_code_o;
    if (zq_timer == '1) begin
      if (pins_b.zq_up && impedance_code_o != ZQ_MAX) begin
        next_zq_code = impedance_code_o + 1'b1;
      end else if (!pins_b.zq_up && impedance_code_o != '0) begin
        next_zq_code = impedance_code_o - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zq_timer <= '0;
      impedance_code_o <= ZQ_MID;
    end else begin
      zq_timer <= next_zq_timer;
      impedance_code_o <= next_zq_code;
    end
  end

  chk_rd_first_comp: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tick && first_beat && !bypass) |-> c_rise) else $error("first read beat not on complement rise");
  chk_rd_second_true: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tick && !bypass && next_rpipe[RD_LAT_TICKS + 1].valid) |-> k_rise) else $error("second beat not on true rise");
  chk_nop_keeps_burst: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(rpipe[2].valid) |-> ##[1:100] rpipe[5].valid) else $error("read burst cut short");
  chk_echo_pair: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    echo_strobe_o != echo_strobe_comp_o) else $error("echo strobes not complementary");
  chk_valid_lead: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(read_valid_flag_o) |-> ##[1:60] (tick && first_beat)) else $error("valid flag without following beat");
  chk_write_commit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    commit_now |-> wbuf[commit_slot].valid && $past(wpipe[WR_COMMIT_TICK - 2].valid, 1) == 1'b0 ||
      wbuf[commit_slot].valid) else $error("commit without buffered write");
  chk_no_write_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (k_rise && pins_b.wr_n) |-> !next_wpipe[0].valid) else $error("write started while deselected");
  chk_bypass_latency: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tick && bypass && first_beat) |-> k_rise) else $error("bypass first beat not one cycle late");
  chk_dll_relock: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    dll_reset |=> (lock_cnt == 12'h000) && !dll_locked_o) else $error("loop reset did not drop lock");
  chk_zq_step: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $changed(impedance_code_o) |-> $past(zq_timer) == '1) else $error("impedance stepped off schedule");

  cov_read_burst: cover property (@(posedge clock_i) disable iff (!reset_n_i) tick && first_beat);
  cov_write_commit: cover property (@(posedge clock_i) disable iff (!reset_n_i) commit_now);
  cov_concurrent: cover property (@(posedge clock_i) disable iff (!reset_n_i) rd_accept && wr_accept);
  cov_locked: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(dll_locked_o));
endmodule

// ---- ddrsp_ctrl_model.sv ----
// Memory-controller model: makes the link clocks, issues commands and late-write beats, captures read beats.
`timescale 1ns/10ps
module ddrsp_ctrl_model (
  input wire logic clock_i,
  input wire logic [ddrsp_pkg::DATA_W-1:0] read_data_i,
  input wire logic echo_strobe_i,
  input wire logic echo_strobe_comp_i,
  input wire logic read_valid_flag_i,
  output ddrsp_pkg::ddrsp_pins_type pins_o
);
  import ddrsp_pkg::*;
  logic [DATA_W-1:0] wq_d[$];
  logic [LANES-1:0] wq_m[$];
  logic [DATA_W-1:0] rbeat[$];
  int rtick[$];
  int tick_no = 0;
  int last_rd_tick = 0;
  logic last_es = 1'b0;
  logic last_v = 1'b0;
  logic tail = 1'b0;

  initial begin
    pins_o = '0;
    pins_o.kc = 1'b1;
    pins_o.rd_n = 1'b1;
    pins_o.wr_n = 1'b1;
    pins_o.bw_n = 4'hF;
    pins_o.bypass_n = 1'b1;
    pins_o.zq_up = 1'b1;
  end

  task automatic put_beat();
    if (wq_d.size() > 0) begin
      pins_o.wdata = wq_d.pop_front();
      pins_o.bw_n = wq_m.pop_front();
    end else begin
      // Released data lines flip so a stale beat can never be taken for a fresh one.
      pins_o.wdata = ~pins_o.wdata;
      pins_o.bw_n = 4'hF;
    end
  endtask

  // One link cycle, entered at a local falling edge half a link phase before the true-clock rise.
  task automatic issue(input logic rn, input logic [ADDR_W-1:0] ra, input logic wn, input logic [ADDR_W-1:0] wa,
                       input logic [BEATS-1:0][DATA_W-1:0] d, input logic [BEATS-1:0][LANES-1:0] m);
    pins_o.rd_n = rn;
    pins_o.wr_n = wn;
    pins_o.raddr = rn ? ~pins_o.raddr : ra;
    pins_o.waddr = wn ? ~pins_o.waddr : wa;
    put_beat();
    #40;
    pins_o.k = 1'b1;
    pins_o.kc = 1'b0;
    if (!rn) last_rd_tick = tick_no + 1;
    #40;
    put_beat();
    #40;
    pins_o.k = 1'b0;
    pins_o.kc = 1'b1;
    #40;
    if (!wn) for (int b = 0; b < BEATS; b++) begin
      wq_d.push_back(d[b]);
      wq_m.push_back(m[b]);
    end
  endtask

  task automatic halt(input int n);
    #(n * 8);
  endtask

  task automatic set_bypass(input logic v);
    pins_o.bypass_n = v;
  endtask

  task automatic set_zq(input logic v);
    pins_o.zq_up = v;
  endtask

  // Beats are taken on strobe changes and qualified by the valid flag, one beat beyond its fall.
  always @(posedge clock_i) begin
    if (echo_strobe_i !== last_es && echo_strobe_comp_i === ~echo_strobe_i) begin
      tick_no = tick_no + 1;
      if (last_v || tail) begin
        rbeat.push_back(read_data_i);
        rtick.push_back(tick_no);
      end
      tail = last_v && !read_valid_flag_i;
      last_v = read_valid_flag_i;
      last_es = echo_strobe_i;
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the burst-of-four SRAM port.
`timescale 1ns/10ps
module tb_top;
  import ddrsp_pkg::*;
  localparam logic [ADDR_W-1:0] A = 19'h00100;
  localparam logic [ADDR_W-1:0] B = 19'h00200;
  localparam logic [BEATS-1:0][LANES-1:0] ALL = 16'h0000;
  localparam logic [BEATS-1:0][LANES-1:0] NONE = 16'hFFFF;
  localparam logic [BEATS-1:0][LANES-1:0] DIAG = 16'h8421;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  ddrsp_pins_type pins;
  logic [DATA_W-1:0] rdata;
  logic es, esc, vld, locked;
  logic [ZQ_W-1:0] zq;
  int bad_count = 0;
  int n_tests = 0;

  initial begin
    forever #4 clock = ~clock;
  end

  ddrsp_port #(.STOP_CYC(25)) dut (.clock_i(clock), .reset_n_i(reset_n), .primary_timing_true_i(pins.k),
    .primary_timing_comp_i(pins.kc), .read_select_n_i(pins.rd_n), .write_select_n_i(pins.wr_n),
    .read_addr_i(pins.raddr), .write_addr_i(pins.waddr), .write_data_i(pins.wdata), .byte_write_n_i(pins.bw_n),
    .loop_bypass_n_i(pins.bypass_n), .impedance_up_i(pins.zq_up), .read_data_o(rdata), .echo_strobe_o(es),
    .echo_strobe_comp_o(esc), .read_valid_flag_o(vld), .impedance_code_o(zq), .dll_locked_o(locked));

  ddrsp_ctrl_model ctl (.clock_i(clock), .read_data_i(rdata), .echo_strobe_i(es), .echo_strobe_comp_i(esc),
    .read_valid_flag_i(vld), .pins_o(pins));

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) ctl.issue(1'b1, '0, 1'b1, '0, '0, NONE);
  endtask

  function automatic logic [BEATS-1:0][DATA_W-1:0] burst(input int s);
    logic [BEATS-1:0][DATA_W-1:0] r;
    for (int b = 0; b < BEATS; b++) r[b] = DATA_W'(s * 4096 + b * 16 + 5);
    return r;
  endfunction

  function automatic logic [BEATS-1:0][DATA_W-1:0] merge(input logic [BEATS-1:0][DATA_W-1:0] o,
                                                         input logic [BEATS-1:0][DATA_W-1:0] n,
                                                         input logic [BEATS-1:0][LANES-1:0] m);
    logic [BEATS-1:0][DATA_W-1:0] r;
    for (int b = 0; b < BEATS; b++) begin
      for (int l = 0; l < LANES; l++) begin
        r[b][l*LANE_W +: LANE_W] = m[b][l] ? o[b][l*LANE_W +: LANE_W] : n[b][l*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  task automatic collect(input logic [BEATS-1:0][DATA_W-1:0] exp, input int t0, input int first);
    for (int b = 0; b < BEATS && first + b < ctl.rbeat.size(); b++) begin
      chk("read beat", exp[b], ctl.rbeat[first+b]);
      chk("beat tick", DATA_W'(t0 + b), DATA_W'(ctl.rtick[first+b]));
    end
  endtask

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [BEATS-1:0][DATA_W-1:0] exp, input int lat);
    int t0;
    ctl.rbeat.delete();
    ctl.rtick.delete();
    ctl.issue(1'b0, a, 1'b1, '0, '0, NONE);
    t0 = ctl.last_rd_tick;
    idle(5);
    chk("beat count", DATA_W'(BEATS), DATA_W'(ctl.rbeat.size()));
    collect(exp, t0 + lat, 0);
  endtask

  task automatic t_reset();
    int t;
    chk("echo", '0, DATA_W'(es));
    chk("echo comp", DATA_W'(1), DATA_W'(esc));
    chk("valid", '0, DATA_W'(vld));
    chk("impedance", DATA_W'(ZQ_MID), DATA_W'(zq));
    chk("lock", '0, DATA_W'(locked));
    t = ctl.tick_no;
    idle(10);
    chk("echo ticks", DATA_W'(20), DATA_W'(ctl.tick_no - t));
    $display("done reset");
  endtask

  task automatic t_zq();
    idle(42);
    chk("impedance top", DATA_W'(ZQ_MAX), DATA_W'(zq));
    ctl.set_zq(1'b0);
    idle(4);
    chk("impedance tracks", DATA_W'(1), DATA_W'(zq < ZQ_MAX));
    $display("done impedance");
  endtask

  task automatic t_lock();
    // Start from a stopped-clock loop reset so the lock count is known; the first rise after it is not counted.
    ctl.halt(40);
    idle(2040);
    chk("lock early", '0, DATA_W'(locked));
    idle(10);
    chk("lock", DATA_W'(1), DATA_W'(locked));
    ctl.halt(40);
    chk("lock after stop", '0, DATA_W'(locked));
    idle(2060);
    chk("relock", DATA_W'(1), DATA_W'(locked));
    $display("done lock");
  endtask

  task automatic t_write_read();
    logic [BEATS-1:0][DATA_W-1:0] e;
    ctl.issue(1'b1, '0, 1'b0, A, burst(1), ALL);
    ctl.issue(1'b1, '0, 1'b0, A, burst(3), ALL);
    rd_check(A, burst(1), 5);
    idle(3);
    rd_check(A, burst(1), 5);
    e = merge(burst(1), burst(2), DIAG);
    ctl.issue(1'b1, '0, 1'b0, A, burst(2), DIAG);
    rd_check(A, e, 5);
    idle(3);
    rd_check(A, e, 5);
    $display("done write and read");
  endtask

  task automatic t_concurrent();
    int t0;
    ctl.rbeat.delete();
    ctl.rtick.delete();
    // Read and write of one fresh address on one edge: the first two beats can only come from the buffer.
    ctl.issue(1'b0, B, 1'b0, B, burst(4), ALL);
    t0 = ctl.last_rd_tick;
    ctl.issue(1'b0, A, 1'b1, '0, '0, NONE);
    idle(1);
    ctl.issue(1'b0, A, 1'b1, '0, '0, NONE);
    idle(5);
    chk("beat count", DATA_W'(2 * BEATS), DATA_W'(ctl.rbeat.size()));
    collect(burst(4), t0 + 5, 0);
    collect(merge(burst(1), burst(2), DIAG), t0 + 6 + 5, BEATS);
    $display("done concurrent");
  endtask

  task automatic t_bypass();
    ctl.set_bypass(1'b0);
    idle(2);
    rd_check(B, burst(4), 2);
    ctl.set_bypass(1'b1);
    idle(2);
    chk("lock after bypass", '0, DATA_W'(locked));
    $display("done bypass");
  endtask

  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_zq();
    t_write_read();
    t_concurrent();
    t_lock();
    t_bypass();
    wrap_up();
  end

  initial begin
    #(96000 * 8);
    bad_count++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
